//--- common/haw_pkg.sv
// Summary of operation
// RULE1 - Default divider gives one timer tick per 1 ms at a 14.7456 MHz clock.
// RULE2 - Tick period is four times the 16-bit divider value in clock cycles.
// RULE3 - Divider low byte sits in the lower lane, high byte above it.
// RULE4 - Watchdog times out after a fixed 2^16 ticks; only the divider changes it. The code sets the count with TIMEOUT_TICKS (4 in the testbench).
// RULE5 - Any host character restarts the count; expiry needs a full silent count.
// RULE6 - Enabled expiry with nonzero vector jumps to the macro after the current character.
// RULE7 - Firing clears the enable flag and releases input waiting for end of line.
// RULE8 - The factory watchdog macro only sends the character w to the host.
// RULE9 - Host or macro must reset bus state with stop, start or select afterwards.
// RULE10 - Reinitialise command acts only when followed by key byte 5A.
// RULE11 - Host keeps at most one wait-for-end-of-line phrase buffered on samples.
// RULE12 - End-of-line character defaults to line feed 0x0A and is configurable.
// RULE13 - After firing no new event occurs until software sets the enable again.
package haw_pkg;
  localparam int unsigned CLK_HZ = 14745600;
  localparam int unsigned TICK_RATE_HZ = 1000;
  localparam int unsigned TICK_PRESCALE = 4;
  localparam logic [15:0] DIV_RESET =
    16'((CLK_HZ + (TICK_PRESCALE * TICK_RATE_HZ) / 2) / (TICK_PRESCALE * TICK_RATE_HZ));
  localparam int unsigned WDOG_TICK_BITS = 16;
  localparam int unsigned WDOG_TICKS = 1 << WDOG_TICK_BITS;
  localparam int unsigned WCNT_W = WDOG_TICK_BITS + 1;
  localparam int unsigned AW = 8;
  localparam logic [7:0] OFF_DIV = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_VECTOR = 8'h08;
  localparam logic [7:0] OFF_EOL = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_COUNT = 8'h18;
  localparam logic [7:0] OFF_MACRO_PRESET = 8'h1C;
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_SLEEP_BIT = 1;
  localparam int unsigned ST_EXPIRE_BIT = 0;
  localparam int unsigned ST_FIRE_BIT = 1;
  localparam int unsigned ST_REINIT_BIT = 2;
  localparam int unsigned ST_W = 3;
  localparam logic [7:0] EOL_RESET = 8'h0A;
  localparam logic [7:0] VECTOR_RESET = 8'h70;
  localparam logic [7:0] FACTORY_MACRO_CHAR = 8'h77;
  localparam logic [7:0] CMD_REINIT_CHAR = 8'h58;
  localparam logic [7:0] REINIT_KEY = 8'h5A;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

//--- hdl/haw_guard_cnt.sv
`timescale 1ns/1ps
module haw_guard_cnt
  import haw_pkg::*;
#(
  parameter int unsigned TIMEOUT_TICKS = WDOG_TICKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic restart,
  output logic [WCNT_W-1:0] count,
  output logic expire
);
  // The count saturates so that one silent spell gives exactly one expiry.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (restart) begin
        count <= '0; // RULE5
      end else if (tick && count < WCNT_W'(TIMEOUT_TICKS)) begin
        count <= count + WCNT_W'(1);
        expire <= (count == WCNT_W'(TIMEOUT_TICKS - 1)); // RULE4
      end
    end
  end

  chk_expire_full: assert property (@(posedge aclk) disable iff (!aresetn)
    expire |-> count == WCNT_W'(TIMEOUT_TICKS)) // RULE4
    else $error("expiry without a full count");
  chk_restart_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    restart |=> count == '0 && !expire) // RULE5
    else $error("host character did not restart the count");
endmodule // haw_guard_cnt

//--- hdl/haw_tick_gen.sv
`timescale 1ns/1ps
module haw_tick_gen
  import haw_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] divider,
  output logic tick
);
  logic [1:0] pre_q;
  logic [15:0] cnt_q;
  logic [15:0] last;

  // A zero divider would stall the timer, so it behaves like one.
  assign last = (divider == 16'h0000) ? 16'h0000 : divider - 16'h0001;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 2'h0;
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end else begin
      pre_q <= pre_q + 2'h1; // RULE2
      tick <= 1'b0;
      if (pre_q == 2'(TICK_PRESCALE - 1)) begin
        if (cnt_q >= last) begin
          cnt_q <= 16'h0000;
          tick <= 1'b1; // RULE1
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
    end
  end

  chk_tick_single: assert property (@(posedge aclk) disable iff (!aresetn)
    tick |=> !tick) // RULE2
    else $error("tick lasted more than one cycle");
endmodule // haw_tick_gen

//--- hdl/haw_top.sv
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module haw_top #(
  parameter int unsigned TIMEOUT_TICKS = haw_pkg::WDOG_TICKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [haw_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [haw_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_char_valid,
  input wire logic exec_char_valid,
  input wire logic [7:0] exec_char,
  input wire logic exec_busy,
  output logic macro_jump,
  output logic [7:0] macro_vector,
  output logic eol_release,
  output logic [7:0] eol_char,
  output logic reinit_req,
  output logic timer_tick,
  output logic irq
);
  import haw_pkg::*;

  logic [15:0] timer_tick_divider_q;
  logic host_activity_guard_enable_q;
  logic sleep_permit_bit_q;
  logic [7:0] vector_q;
  logic [7:0] eol_q;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [ST_W-1:0] events;
  logic [WCNT_W-1:0] wd_count;
  logic wd_expire;
  logic fire;
  logic redirect_pend_q;
  logic reinit_armed_q;
  logic aw_have_q;
  logic w_have_q;
  logic [AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_do;
  logic rd_do;
  logic rd_status;
  logic soft_init;

  function automatic logic known_offset(input logic [AW-1:0] a);
    unique case (a)
      OFF_DIV, OFF_CTRL, OFF_VECTOR, OFF_EOL, OFF_STATUS, OFF_MASK, OFF_COUNT,
      OFF_MACRO_PRESET: known_offset = 1'b1;
      default: known_offset = 1'b0;
    endcase
  endfunction

  function automatic logic wr_hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
    wr_hit = (a == off);
  endfunction

  // Write channel: address and data are taken in either order.
  assign wr_do = aw_have_q && w_have_q && !s_axi_bvalid;
  assign rd_do = s_axi_arvalid && s_axi_arready;
  assign rd_status = rd_do && s_axi_araddr == OFF_STATUS;
  assign soft_init = reinit_req;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_do) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= known_offset(aw_addr_q) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: one cycle from address to data, held until taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_do;
      if (rd_do) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= known_offset(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
        unique case (s_axi_araddr)
          OFF_DIV: s_axi_rdata <= {16'h0000, timer_tick_divider_q};
          OFF_CTRL: s_axi_rdata <= {30'h0, sleep_permit_bit_q, host_activity_guard_enable_q};
          OFF_VECTOR: s_axi_rdata <= {24'h000000, vector_q};
          OFF_EOL: s_axi_rdata <= {24'h000000, eol_q};
          OFF_STATUS: s_axi_rdata <= {29'h0, status_q};
          OFF_MASK: s_axi_rdata <= {29'h0, mask_q};
          OFF_COUNT: s_axi_rdata <= 32'(wd_count);
          OFF_MACRO_PRESET: s_axi_rdata <= {24'h000000, FACTORY_MACRO_CHAR}; // RULE8
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Settings return to their power-on values on reset and on a keyed reinitialise.
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_init) begin // RULE10
      timer_tick_divider_q <= DIV_RESET; // RULE1
      vector_q <= VECTOR_RESET;
      eol_q <= EOL_RESET; // RULE12
      mask_q <= '0;
      sleep_permit_bit_q <= 1'b0;
    end else if (wr_do) begin
      if (wr_hit(aw_addr_q, OFF_DIV)) begin
        if (w_strb_q[0]) timer_tick_divider_q[7:0] <= w_data_q[7:0]; // RULE3
        if (w_strb_q[1]) timer_tick_divider_q[15:8] <= w_data_q[15:8]; // RULE3
      end
      if (wr_hit(aw_addr_q, OFF_VECTOR) && w_strb_q[0]) vector_q <= w_data_q[7:0];
      if (wr_hit(aw_addr_q, OFF_EOL) && w_strb_q[0]) eol_q <= w_data_q[7:0]; // RULE12
      if (wr_hit(aw_addr_q, OFF_MASK) && w_strb_q[0]) mask_q <= w_data_q[ST_W-1:0];
      if (wr_hit(aw_addr_q, OFF_CTRL) && w_strb_q[0]) begin
        sleep_permit_bit_q <= w_data_q[CTRL_SLEEP_BIT];
      end
    end
  end

  // A software write in the same cycle as a firing wins, so a re-arm is never lost.
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_init) begin
      host_activity_guard_enable_q <= 1'b0;
    end else if (wr_do && wr_hit(aw_addr_q, OFF_CTRL) && w_strb_q[0]) begin
      host_activity_guard_enable_q <= w_data_q[CTRL_ENABLE_BIT]; // RULE13
    end else if (fire) begin
      host_activity_guard_enable_q <= 1'b0; // RULE7
    end
  end

  haw_tick_gen u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .divider(timer_tick_divider_q),
    .tick(timer_tick)
  );

  haw_guard_cnt #(
    .TIMEOUT_TICKS(TIMEOUT_TICKS)
  ) u_guard (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(timer_tick),
    .restart(rx_char_valid), // RULE5
    .count(wd_count),
    .expire(wd_expire)
  );

  // The counter keeps running while disarmed; the enable and a nonzero vector gate the event.
  assign fire = wd_expire && host_activity_guard_enable_q && vector_q != 8'h00; // RULE6 RULE13

  // The jump waits for the executor to finish the character it holds.
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_init) begin
      redirect_pend_q <= 1'b0;
      macro_jump <= 1'b0;
      macro_vector <= 8'h00;
      eol_release <= 1'b0;
    end else begin
      macro_jump <= 1'b0;
      eol_release <= fire; // RULE7
      if (fire) begin
        redirect_pend_q <= 1'b1;
        macro_vector <= vector_q;
      end else if (redirect_pend_q && !exec_busy) begin
        redirect_pend_q <= 1'b0;
        macro_jump <= 1'b1; // RULE6
      end
    end
  end

  assign eol_char = eol_q;

  // Reinitialise needs the command character immediately followed by the key.
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_init) begin
      reinit_armed_q <= 1'b0;
      reinit_req <= 1'b0;
    end else begin
      reinit_req <= 1'b0;
      if (exec_char_valid) begin
        reinit_armed_q <= (exec_char == CMD_REINIT_CHAR);
        reinit_req <= reinit_armed_q && exec_char == REINIT_KEY; // RULE10
      end
    end
  end

  assign events = {soft_init, fire, wd_expire};

  // A new event beats the clear of a status read in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
      irq <= 1'b0;
    end else begin
      status_q <= (rd_status ? '0 : status_q) | events;
      irq <= |(((rd_status ? '0 : status_q) | events) & mask_q);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_fire_needs_vector: assert property (macro_jump |-> macro_vector != 8'h00) // RULE6
    else $error("macro jump to a zero vector");
  chk_jump_after_busy: assert property (macro_jump |-> !$past(exec_busy)) // RULE6
    else $error("macro jump while current character was busy");
  chk_fire_clears_en: assert property (fire && !(wr_do && wr_hit(aw_addr_q, OFF_CTRL))
    |=> !host_activity_guard_enable_q) // RULE7
    else $error("enable flag survived a firing");
  chk_eol_release: assert property (fire |=> eol_release ##1 !eol_release) // RULE7
    else $error("queued input was not released once");
  chk_no_rearm: assert property (wd_expire && !host_activity_guard_enable_q
    |=> !eol_release) // RULE13
    else $error("event raised while disarmed");
  chk_reinit_key: assert property (exec_char_valid && exec_char != REINIT_KEY
    |=> !reinit_req) // RULE10
    else $error("reinitialise without key byte");
  chk_reinit_defaults: assert property (reinit_req |=> eol_q == EOL_RESET &&
    timer_tick_divider_q == DIV_RESET) // RULE10 RULE12
    else $error("reinitialise did not restore defaults");
  chk_status_sticky: assert property (wd_expire |=> status_q[ST_EXPIRE_BIT]) // RULE5
    else $error("expiry was not recorded");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");

  cov_fire_jump: cover property (fire ##[1:20] macro_jump);
  cov_reinit: cover property (reinit_req);
  cov_irq: cover property (irq && status_q[ST_FIRE_BIT]);
endmodule // haw_top

//--- tb/haw_host_model.sv
`timescale 1ns/1ps
// Stands in for the host link and the command executor around the guard.
module haw_host_model (
  input wire logic aclk,
  output logic rx_char_valid,
  output logic exec_char_valid,
  output logic [7:0] exec_char,
  output logic exec_busy
);
  initial begin
    rx_char_valid = 1'b0;
    exec_char_valid = 1'b0;
    exec_char = 8'hA5;
    exec_busy = 1'b0;
  end
  // One host character per call, so a second end-of-line phrase never queues up.
  task automatic host_char();
    rx_char_valid <= 1'b1;
    @(posedge aclk);
    rx_char_valid <= 1'b0;
  endtask
  // Idle data lines carry the inverse, so a stale character can never pass for a new one.
  task automatic exec_put(input logic [7:0] c);
    exec_char <= c;
    exec_char_valid <= 1'b1;
    @(posedge aclk);
    exec_char_valid <= 1'b0;
    exec_char <= ~c;
    // One idle edge keeps a following call from driving the strobe twice in one step.
    @(posedge aclk);
  endtask
  task automatic set_busy(input logic b);
    exec_busy <= b;
  endtask
endmodule // haw_host_model

//--- tb/haw_top_tb.sv
`timescale 1ns/1ps
module haw_top_tb;
  import haw_pkg::*;
  logic aclk = 1'b0;
  logic aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr, macro_vector, eol_char, exec_char;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic rx_char_valid, exec_char_valid, exec_busy, macro_jump, eol_release;
  logic reinit_req, timer_tick, irq;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  int last_tick = 0;
  int tick_gap = 0;
  int ticks_since = 0;
  int fire_ticks = 0;
  int n_eol = 0;
  int n_jump = 0;
  int n_reinit = 0;
  logic slow = 1'b0;

  always #5 aclk = ~aclk;

  haw_top #(.TIMEOUT_TICKS(4)) i_haw_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_char_valid(rx_char_valid),
    .exec_char_valid(exec_char_valid), .exec_char(exec_char), .exec_busy(exec_busy),
    .macro_jump(macro_jump), .macro_vector(macro_vector), .eol_release(eol_release),
    .eol_char(eol_char), .reinit_req(reinit_req), .timer_tick(timer_tick), .irq(irq));

  haw_host_model i_haw_host_model (.aclk(aclk), .rx_char_valid(rx_char_valid),
    .exec_char_valid(exec_char_valid), .exec_char(exec_char), .exec_busy(exec_busy));

  // Pulse outputs last one cycle, so they are counted here rather than polled by the tests.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (timer_tick === 1'b1) begin
      tick_gap <= cyc - last_tick;
      last_tick <= cyc;
    end
    if (rx_char_valid) ticks_since <= 0;
    else if (timer_tick === 1'b1) ticks_since <= ticks_since + 1;
    if (eol_release === 1'b1) begin
      n_eol <= n_eol + 1;
      fire_ticks <= ticks_since;
    end
    if (macro_jump === 1'b1) n_jump <= n_jump + 1;
    if (reinit_req === 1'b1) n_reinit <= n_reinit + 1;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tend(input string name);
    $display("test %s done, mismatches so far %0d", name, fails);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] re);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // A slow master withholds bready until the response has stood for one edge.
    s_axi_bready <= !slow;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready) && n < 100);
    s_axi_bready <= 1'b0;
    if (n >= 100) fails++;
    chk($sformatf("write response at %h", a), 32'(s_axi_bresp), 32'(re));
    @(posedge aclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !slow;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid === 1'b1 && s_axi_rready) && n < 100);
    s_axi_rready <= 1'b0;
    if (n >= 100) fails++;
    chk($sformatf("read data at %h", a), s_axi_rdata, e);
    chk($sformatf("read response at %h", a), 32'(s_axi_rresp), 32'(re));
    @(posedge aclk);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    close_out();
  end

  initial begin
    int n;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(OFF_DIV, 32'h0000_0E66, RESP_OKAY);
    rdc(OFF_EOL, 32'h0000_000A, RESP_OKAY);
    rdc(OFF_MACRO_PRESET, 32'h0000_0077, RESP_OKAY);
    rdc(8'h40, 32'h0000_0000, RESP_DECERR);
    wrc(8'h40, 32'hFFFF_FFFF, 4'hF, RESP_DECERR);
    wrc(OFF_EOL, 32'h0000_000D, 4'h1, RESP_OKAY);
    chk("eol char", 32'(eol_char), 32'h0000_000D);
    tend("reset and map");
    wrc(OFF_DIV, 32'h0000_0034, 4'h1, RESP_OKAY);
    wrc(OFF_DIV, 32'h0000_1200, 4'h2, RESP_OKAY);
    rdc(OFF_DIV, 32'h0000_1234, RESP_OKAY);
    wrc(OFF_DIV, 32'h0000_0002, 4'h3, RESP_OKAY);
    repeat (30) @(posedge aclk);
    chk("tick period", tick_gap, 32'd8);
    wrc(OFF_DIV, 32'h0000_0001, 4'h3, RESP_OKAY);
    repeat (16) @(posedge aclk);
    chk("tick period", tick_gap, 32'd4);
    tend("divider");
    wrc(OFF_MASK, 32'h0000_0007, 4'h1, RESP_OKAY);
    wrc(OFF_CTRL, 32'h0000_0001, 4'h1, RESP_OKAY);
    i_haw_host_model.set_busy(1'b1);
    repeat (6) begin
      i_haw_host_model.host_char();
      repeat (10) @(posedge aclk);
    end
    chk("early fire", n_eol, 32'd0);
    i_haw_host_model.host_char();
    n = 0;
    while (eol_release !== 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    repeat (3) @(posedge aclk);
    chk("ticks to fire", fire_ticks, 32'd4);
    chk("eol releases", n_eol, 32'd1);
    chk("jump while busy", n_jump, 32'd0);
    chk("vector", 32'(macro_vector), 32'h0000_0070);
    chk("irq raised", 32'(irq), 32'd1);
    i_haw_host_model.set_busy(1'b0);
    repeat (4) @(posedge aclk);
    chk("jumps", n_jump, 32'd1);
    i_haw_host_model.exec_put(8'h50);
    slow = 1'b1;
    rdc(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
    rdc(OFF_STATUS, 32'h0000_0003, RESP_OKAY);
    rdc(OFF_STATUS, 32'h0000_0000, RESP_OKAY);
    chk("irq cleared", 32'(irq), 32'd0);
    tend("fire");
    wrc(OFF_MASK, 32'h0000_0000, 4'h1, RESP_OKAY);
    slow = 1'b0;
    i_haw_host_model.host_char();
    repeat (40) @(posedge aclk);
    chk("no refire", n_eol, 32'd1);
    chk("irq masked", 32'(irq), 32'd0);
    rdc(OFF_STATUS, 32'h0000_0001, RESP_OKAY);
    rdc(OFF_COUNT, 32'h0000_0004, RESP_OKAY);
    wrc(OFF_VECTOR, 32'h0000_0000, 4'h1, RESP_OKAY);
    wrc(OFF_CTRL, 32'h0000_0003, 4'h1, RESP_OKAY);
    i_haw_host_model.host_char();
    repeat (40) @(posedge aclk);
    chk("zero vector fire", n_eol, 32'd1);
    rdc(OFF_CTRL, 32'h0000_0003, RESP_OKAY);
    rdc(OFF_STATUS, 32'h0000_0001, RESP_OKAY);
    tend("no refire");
    i_haw_host_model.exec_put(CMD_REINIT_CHAR);
    i_haw_host_model.exec_put(8'h5B);
    i_haw_host_model.exec_put(8'h5A);
    repeat (3) @(posedge aclk);
    chk("wrong key", n_reinit, 32'd0);
    i_haw_host_model.exec_put(CMD_REINIT_CHAR);
    i_haw_host_model.exec_put(8'h5A);
    repeat (3) @(posedge aclk);
    chk("reinit", n_reinit, 32'd1);
    rdc(OFF_DIV, 32'h0000_0E66, RESP_OKAY);
    rdc(OFF_STATUS, 32'h0000_0004, RESP_OKAY);
    tend("reinit");
    close_out();
  end
endmodule // haw_top_tb
